// ### bench/byte_rotate_unit_test.sv
`timescale 1ns/1ns
module byte_rotate_unit_test;
  import rotate_pkg::*;
  localparam logic [7:0] lm = 8'h87, th = 8'h66, mm = 8'h2b;
  logic clock = 0, sys_rst = 1, op_valid = 0, carry_in = 0, carry_out, carry_write, mem_write, wreg_write, done, l, t, x;
  logic [7:0] operand = 8'h00, result;
  logic [8:0] q[$];
  logic [2:0] qs[$];
  logic [31:0] lf = 97909;
  rot_op_e op_code = rotate_left_plain;
  int miscompares = 0, n_checks = 0;
  byte_rotate_unit dut_u (.*);
  initial forever #5 clock = ~clock;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp_strobe(logic [2:0] e, logic [2:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t %h %h", $time, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d bad %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp(logic [8:0] e, logic [8:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t %h %h", $time, e, g);
    end
  endtask
  always @(negedge clock)
    if (done === 1'b1)
    begin
      cmp(q.pop_front(), {carry_out, result});
      cmp_strobe(qs.pop_front(), {carry_write, mem_write, wreg_write});
    end
    else
      cmp_strobe(3'b000, {carry_write, mem_write, wreg_write});
  initial
  begin
    #9000 miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge clock);
    #1 sys_rst = 0;
    repeat (300)
    begin
      @(posedge clock);
      #1 lf = lfsr_next(lf);
      {carry_in, operand, op_valid} = lf[9:0];
      op_code = rot_op_e'(lf[12:10]);
      {l, t, x} = {lm[op_code], th[op_code], lm[op_code] ? operand[7] : operand[0]};
      if (op_valid)
      begin
        q.push_back({t ? x : carry_in, l ? {operand[6:0], t ? carry_in : x} : {t ? carry_in : x, operand[7:1]}});
        qs.push_back({t, mm[op_code], ~mm[op_code]});
      end
    end
    @(posedge clock);
    #1 op_valid = 0;
    #20;
    // Every request must have produced its answer
    if (q.size() != 0)
      miscompares++;
    end_sim;
  end
endmodule

// ### bench/rotate_asserts.sv
`timescale 1ns/1ns
module rotate_asserts
(
  input wire logic clock, sys_rst, op_valid, carry_in, carry_out, carry_write, mem_write, wreg_write, done,
  input wire rotate_pkg::rot_op_e op_code,
  input wire logic [7:0] operand, result
);
  // One bit per op code: left, through carry, memory destination
  localparam logic [7:0] lm = 8'h87, th = 8'h66, mm = 8'h2b;
  logic v, l, t, m, c;
  logic [7:0] d;
  always_ff @(posedge clock) {v, l, t, m, d, c} <= {op_valid, lm[op_code], th[op_code], mm[op_code], operand, carry_in};
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_req; op_valid; endsequence
  property p_lt; v && l && t |-> {carry_out, result} == {d, c}; endproperty
  property p_rt; v && !l && t |-> {result, carry_out} == {c, d}; endproperty
  property p_rp; v && !l && !t |-> result == {d[0], d[7:1]}; endproperty
  property p_lp; v && l && !t |-> result == {d[6:0], d[7]}; endproperty
  property p_cf; v |-> carry_write == t && (t || carry_out == c); endproperty
  property p_ds; v |-> mem_write == m && wreg_write == !m; endproperty
  property p_dn; s_req |=> done; endproperty
  property p_id; !v |-> !(done || mem_write || wreg_write || carry_write); endproperty
  a_lt: assert property (p_lt) else $error("rotate");
  a_rt: assert property (p_rt) else $error("rotate");
  a_rp: assert property (p_rp) else $error("rotate");
  a_lp: assert property (p_lp) else $error("rotate");
  a_cf: assert property (p_cf) else $error("carry");
  a_ds: assert property (p_ds) else $error("dest");
  a_dn: assert property (p_dn) else $error("late");
  a_id: assert property (p_id) else $error("idle");
endmodule
bind byte_rotate_unit rotate_asserts chk_u (.*);

// ### core/byte_rotate_unit.sv
`timescale 1ns/1ns
// Summary of operation
// - Left through carry to memory: carry into bit 0, bit 7 to carry.
// - Left through carry to working register: same rotation, memory byte unchanged.
// - Plain right to memory: bit 0 wraps to bit 7, flags untouched.
// - Plain right to working register: wrap rotation, memory unchanged, flags untouched.
// - Right through carry to memory: carry into bit 7, bit 0 to carry.
// - Right through carry to working register: same rotation, memory unchanged.
// - Only through-carry variants change carry; no other flag changes.
// - Plain left: bit 7 wraps to bit 0, no flags, register form keeps memory.
module byte_rotate_unit
  import rotate_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              op_valid,
  input  wire rotate_pkg::rot_op_e op_code,
  input  wire logic [7:0]        operand,
  input  wire logic              carry_in,
  output logic [7:0]             result,
  output logic                   carry_out,
  output logic                   carry_write,
  output logic                   mem_write,
  output logic                   wreg_write,
  output logic                   done
);
  import rotate_pkg::*;

  typedef struct packed
  {
    logic [7:0] result;
    logic       carry_out;
    logic       carry_write;
    logic       mem_write;
    logic       wreg_write;
    logic       done;
  } state_s;

  state_s cur;
  state_s next_cur;

  // Left ring; bit 8 of the answer is the new carry
  function automatic logic [8:0] rotate_left9
  (
    input logic [7:0] value,
    input logic       cin,
    input logic       through_flag
  );
    logic [8:0] res;
    res = 9'h000;
    if (through_flag)
    begin
      res = {value[msb_pos], value[6:0], cin};
    end
    else
    begin
      // Plain form: carry passes through untouched
      res = {cin, value[6:0], value[msb_pos]};
    end
    return res;
  endfunction

  // Right ring; bit 8 of the answer is the new carry
  function automatic logic [8:0] rotate_right9
  (
    input logic [7:0] value,
    input logic       cin,
    input logic       through_flag
  );
    logic [8:0] res;
    res = 9'h000;
    if (through_flag)
    begin
      res = {value[lsb_pos], cin, value[7:1]};
    end
    else
    begin
      // Plain form: carry passes through untouched
      res = {cin, value[lsb_pos], value[7:1]};
    end
    return res;
  endfunction

  // Nine-bit rotate; through_flag puts carry in the ring
  function automatic logic [8:0] rotate9
  (
    input logic [7:0] value,
    input logic       cin,
    input logic       left,
    input logic       through_flag
  );
    logic [8:0] res;
    res = 9'h000;
    if (left)
    begin
      res = rotate_left9(value, cin, through_flag);
    end
    else
    begin
      res = rotate_right9(value, cin, through_flag);
    end
    return res;
  endfunction

  always_comb
  begin
    logic [8:0] rot;
    logic       left;
    logic       thru;
    logic       to_mem;
    rot    = 9'h000;
    left   = 1'b0;
    thru   = 1'b0;
    to_mem = 1'b0;
    next_cur = cur;
    next_cur.carry_write = 1'b0;
    next_cur.mem_write   = 1'b0;
    next_cur.wreg_write  = 1'b0;
    next_cur.done        = 1'b0;
    case (op_code)
      rotate_left_plain:
      begin
        left   = 1'b1;
        to_mem = 1'b1;
      end
      rotate_left_plain_wreg:
      begin
        left = 1'b1;
      end
      rotate_left_thru_flag_mem:
      begin
        left   = 1'b1;
        thru   = 1'b1;
        to_mem = 1'b1;
      end
      rotate_left_thru_flag_wreg:
      begin
        left = 1'b1;
        thru = 1'b1;
      end
      rotate_right_plain_mem:
      begin
        to_mem = 1'b1;
      end
      rotate_right_plain_wreg:
      begin
        to_mem = 1'b0;
      end
      rotate_right_thru_flag_mem:
      begin
        thru   = 1'b1;
        to_mem = 1'b1;
      end
      rotate_right_thru_flag_wreg:
      begin
        thru = 1'b1;
      end
      default:
      begin
        // Every code is decoded; kept for lint
        left = 1'b0;
      end
    endcase
    rot = rotate9(operand, carry_in, left, thru);
    if (op_valid)
    begin
      next_cur.result      = rot[7:0];
      // Plain rotates pass carry through unchanged and never strobe it
      next_cur.carry_out   = rot[8];
      next_cur.carry_write = thru;
      next_cur.mem_write   = to_mem;
      // Register forms never strobe memory so the byte stays intact
      next_cur.wreg_write  = ~to_mem;
      next_cur.done        = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cur <= '{
        result:      result_reset,
        carry_out:   carry_reset,
        carry_write: 1'b0,
        mem_write:   1'b0,
        wreg_write:  1'b0,
        done:        1'b0
      };
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign result      = cur.result;
  assign carry_out   = cur.carry_out;
  assign carry_write = cur.carry_write;
  assign mem_write   = cur.mem_write;
  assign wreg_write  = cur.wreg_write;
  assign done        = cur.done;

endmodule

// ### core/rotate_pkg.sv
package rotate_pkg;

  localparam int unsigned data_width = 8;
  localparam int unsigned msb_pos    = 7;
  localparam int unsigned lsb_pos    = 0;

  localparam logic [7:0] result_reset = 8'h00;
  localparam logic       carry_reset  = 1'b0;

  // Rotate operations
  typedef enum logic [2:0]
  {
    rotate_left_plain,
    rotate_left_thru_flag_mem,
    rotate_left_thru_flag_wreg,
    rotate_right_plain_mem,
    rotate_right_plain_wreg,
    rotate_right_thru_flag_mem,
    rotate_right_thru_flag_wreg,
    rotate_left_plain_wreg
  } rot_op_e;

  typedef enum logic
  {
    dest_memory,
    dest_working_register
  } dest_e;

endpackage
